// ==== cbtp_defs.svh ====
`ifndef CBTP_DEFS_SVH
`define CBTP_DEFS_SVH

// ------------------------------------------------------------------
// Register placement and field layout
// ------------------------------------------------------------------
`define CBTP_REG_ADDR     8'hb5
`define CBTP_SJW_MSB      6
`define CBTP_SJW_LSB      5
`define CBTP_PRS_MSB      3
`define CBTP_PRS_LSB      1
`define CBTP_RES7_BIT     7
`define CBTP_RES4_BIT     4
`define CBTP_RES0_BIT     0

// ------------------------------------------------------------------
// Constant values
// ------------------------------------------------------------------
`define CBTP_RDATA_IDLE   8'h00
`define CBTP_ZERO_BIT     1'h0

`endif

// ==== cbtp_pkg.sv ====
package cbtp_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic {
        CBTP_SEG_IDLE,
        CBTP_SEG_PROP
    } cbtp_seg_state_t;

    typedef logic [1:0] cbtp_sjw_t;
    typedef logic [2:0] cbtp_prs_t;

endpackage

// ==== cbtp_tq_if.sv ====
`timescale 1ns/1ps

interface cbtp_tq_if #(
    parameter int BRP_W = 6
);
    logic [BRP_W-1:0] prescaler;
    logic             enable;
    logic             tick;

    modport gen (
        input  prescaler,
        input  enable,
        output tick
    );

    modport use_side (
        output prescaler,
        output enable,
        input  tick
    );
endinterface

// ==== cbtp_tq_gen.sv ====
`timescale 1ns/1ps

module cbtp_tq_gen #(
    parameter int BRP_W = 6
) (
    // Clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    // Quantum link
    cbtp_tq_if.gen    tq
);
    import cbtp_pkg::*;

    logic [BRP_W-1:0] div_reg;
    logic             tick_reg;
    logic [BRP_W-1:0] gap_reg;
    logic             seen_reg;

    // ------------------------------------------------------------------
    // Quantum divider
    // ------------------------------------------------------------------
    // The quantum lasts one more clock than the prescaler value.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            div_reg  <= '0;
            tick_reg <= 1'b0;
        end else if (!tq.enable) begin
            div_reg  <= '0;
            tick_reg <= 1'b0;
        end else if (div_reg == tq.prescaler) begin
            div_reg  <= '0;
            tick_reg <= 1'b1;
        end else begin
            div_reg  <= div_reg + BRP_W'(1);
            tick_reg <= 1'b0;
        end
    end

    assign tq.tick = tick_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            gap_reg  <= '0;
            seen_reg <= 1'b0;
        end else if (!tq.enable) begin
            gap_reg  <= '0;
            seen_reg <= 1'b0;
        end else if (tick_reg) begin
            gap_reg  <= '0;
            seen_reg <= 1'b1;
        end else begin
            gap_reg  <= gap_reg + BRP_W'(1);
        end
    end

    chk_quantum_period: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (tick_reg && seen_reg && tq.enable && $stable(tq.prescaler))
            |-> (gap_reg == tq.prescaler))
        else $error("quantum period differs from prescaler plus one");

    cov_quantum_tick: cover property (
        @(posedge i_ref_clk) disable iff (i_rst)
        tick_reg && seen_reg);

endmodule // cbtp_tq_gen

// ==== cbtp_top.sv ====
`timescale 1ns/1ps
`include "cbtp_defs.svh"

module cbtp_top
    import cbtp_pkg::*;
#(
    parameter int BRP_W   = 6,
    parameter int PHASE_W = 6
) (
    // Clock and reset
    input  wire logic                      i_ref_clk,
    input  wire logic                      i_rst,
    // Special function register access
    input  wire logic [7:0]                i_sfr_addr,
    input  wire logic [7:0]                i_sfr_wdata,
    input  wire logic                      i_sfr_wr,
    input  wire logic                      i_sfr_rd,
    output logic      [7:0]                o_sfr_rdata,
    // Controller context
    input  wire logic                      i_controller_on_bit,
    input  wire logic [BRP_W-1:0]          i_baud_prescaler,
    // Bit engine requests
    input  wire logic                      i_seg_start,
    input  wire logic                      i_resync_edge,
    input  wire logic signed [PHASE_W-1:0] i_phase_err,
    // Bit engine answers
    output logic                           o_tq_tick,
    output logic                           o_prop_active,
    output logic                           o_prop_done,
    output logic                           o_resync_valid,
    output logic signed [PHASE_W-1:0]      o_resync_adj,
    output cbtp_sjw_t                      o_resync_jump_width,
    output cbtp_prs_t                      o_propagation_segment
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    cbtp_sjw_t                    resync_jump_width_reg;
    cbtp_prs_t                    propagation_segment_reg;
    logic [7:0]                   rdata_reg;
    cbtp_seg_state_t              seg_state_reg;
    cbtp_prs_t                    seg_cnt_reg;
    logic                         prop_done_reg;
    logic                         resync_valid_reg;
    logic signed [PHASE_W-1:0]    resync_adj_reg;
    logic signed [PHASE_W-1:0]    jump_lim;
    logic signed [PHASE_W-1:0]    resync_adj_next;
    logic                         hit;
    logic [3:0]                   tq_seen_reg;

    cbtp_tq_if #(.BRP_W(BRP_W)) tq ();

    assign hit = (i_sfr_addr == `CBTP_REG_ADDR);

    // ------------------------------------------------------------------
    // Timing register
    // ------------------------------------------------------------------
    // No reset branch: the contents stay undefined until written, which
    // saves the reset fan-out on a register that must be programmed anyway.
    always_ff @(posedge i_ref_clk) begin
        if (i_sfr_wr && hit) begin
            resync_jump_width_reg <=
                i_sfr_wdata[`CBTP_SJW_MSB:`CBTP_SJW_LSB];
            propagation_segment_reg <=
                i_sfr_wdata[`CBTP_PRS_MSB:`CBTP_PRS_LSB];
        end
    end

    // Reserved positions are not stored, so ones written there are lost.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_reg <= `CBTP_RDATA_IDLE;
        end else if (i_sfr_rd && hit) begin
            rdata_reg <= {`CBTP_ZERO_BIT, resync_jump_width_reg,
                          `CBTP_ZERO_BIT, propagation_segment_reg,
                          `CBTP_ZERO_BIT};
        end else begin
            rdata_reg <= `CBTP_RDATA_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // Time quantum source
    // ------------------------------------------------------------------
    assign tq.prescaler = i_baud_prescaler;
    assign tq.enable    = i_controller_on_bit;

    cbtp_tq_gen #(
        .BRP_W (BRP_W)
    ) u_tq_gen (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .tq        (tq)
    );

    // ------------------------------------------------------------------
    // Propagation segment timer
    // ------------------------------------------------------------------
    // Starts are ignored while disabled, as the fields may be unprogrammed.
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            seg_state_reg <= CBTP_SEG_IDLE;
            seg_cnt_reg   <= '0;
            prop_done_reg <= 1'b0;
        end else begin
            prop_done_reg <= 1'b0;
            case (seg_state_reg)
                CBTP_SEG_IDLE: begin
                    if (i_seg_start && i_controller_on_bit) begin
                        seg_state_reg <= CBTP_SEG_PROP;
                        seg_cnt_reg   <= '0;
                    end
                end
                CBTP_SEG_PROP: begin
                    if (!i_controller_on_bit) begin
                        seg_state_reg <= CBTP_SEG_IDLE;
                    end else if (tq.tick) begin
                        if (seg_cnt_reg == propagation_segment_reg) begin
                            seg_state_reg <= CBTP_SEG_IDLE;
                            prop_done_reg <= 1'b1;
                        end else begin
                            seg_cnt_reg <= seg_cnt_reg + 3'h1;
                        end
                    end
                end
                default: begin
                    seg_state_reg <= CBTP_SEG_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Resynchronization limiter
    // ------------------------------------------------------------------
    // The jump limit is the field value plus one, so a zero field
    // still allows a single quantum of correction.
    assign jump_lim = $signed(PHASE_W'(resync_jump_width_reg))
                    + $signed(PHASE_W'(1));

    always_comb begin
        resync_adj_next = i_phase_err;
        if (i_phase_err > jump_lim) begin
            resync_adj_next = jump_lim;
        end else if (i_phase_err < -jump_lim) begin
            resync_adj_next = -jump_lim;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            resync_valid_reg <= 1'b0;
            resync_adj_reg   <= '0;
        end else begin
            resync_valid_reg <= i_resync_edge && i_controller_on_bit;
            if (i_resync_edge && i_controller_on_bit) begin
                resync_adj_reg <= resync_adj_next;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_sfr_rdata           = rdata_reg;
    assign o_tq_tick             = tq.tick;
    assign o_prop_active         = (seg_state_reg == CBTP_SEG_PROP);
    assign o_prop_done           = prop_done_reg;
    assign o_resync_valid        = resync_valid_reg;
    assign o_resync_adj          = resync_adj_reg;
    assign o_resync_jump_width   = resync_jump_width_reg;
    assign o_propagation_segment = propagation_segment_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            tq_seen_reg <= '0;
        end else if (seg_state_reg == CBTP_SEG_IDLE) begin
            tq_seen_reg <= '0;
        end else if (tq.tick) begin
            tq_seen_reg <= tq_seen_reg + 4'h1;
        end
    end

    chk_prop_length: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        prop_done_reg |->
            (tq_seen_reg == {1'b0, propagation_segment_reg} + 4'h1))
        else $error("propagation segment length is wrong");

    chk_prop_start: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_seg_start && i_controller_on_bit && !o_prop_active)
            |=> o_prop_active)
        else $error("propagation segment did not start");

    chk_jump_bound: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        resync_valid_reg |->
            (resync_adj_reg <= $past(jump_lim)
             && resync_adj_reg >= -$past(jump_lim)))
        else $error("resync correction exceeds jump width");

    chk_jump_pass: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_resync_edge && i_controller_on_bit
         && i_phase_err <= jump_lim && i_phase_err >= -jump_lim)
            |=> (resync_valid_reg && resync_adj_reg == $past(i_phase_err)))
        else $error("small phase error not applied in full");

    chk_reserved_zero: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        !rdata_reg[`CBTP_RES7_BIT] && !rdata_reg[`CBTP_RES4_BIT]
            && !rdata_reg[`CBTP_RES0_BIT])
        else $error("reserved bit read as one");

    chk_read_back: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_sfr_wr && hit) ##1 (i_sfr_rd && hit && !i_sfr_wr)
            |=> (rdata_reg[`CBTP_SJW_MSB:`CBTP_SJW_LSB]
                     == $past(i_sfr_wdata[`CBTP_SJW_MSB:`CBTP_SJW_LSB], 2)
                 && rdata_reg[`CBTP_PRS_MSB:`CBTP_PRS_LSB]
                     == $past(i_sfr_wdata[`CBTP_PRS_MSB:`CBTP_PRS_LSB], 2)))
        else $error("written fields not read back");

    cov_prop_done: cover property (
        @(posedge i_ref_clk) disable iff (i_rst)
        prop_done_reg && propagation_segment_reg == 3'h7);

    cov_jump_clamp: cover property (
        @(posedge i_ref_clk) disable iff (i_rst)
        i_resync_edge && i_controller_on_bit && i_phase_err < -jump_lim);

    cov_reg_read: cover property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_sfr_wr && hit) ##1 (i_sfr_rd && hit));

endmodule // cbtp_top

// ==== cbtp_node_model.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Far-side node: relevant edges and segment starts for the bit engine
// ------------------------------------------------------------------
module cbtp_node_model (
    // Clock
    input  wire logic          i_ref_clk,
    // Bit engine requests
    output logic               o_seg_start,
    output logic               o_resync_edge,
    output logic signed [5:0]  o_phase_err
);
    initial begin
        o_seg_start   = 1'h0;
        o_resync_edge = 1'h0;
        o_phase_err   = 6'h00;
    end

    // A late node idles first, toggling the error lines each idle cycle; after an
    // edge they hold the inverted error, so a stale error can never be taken for a fresh one.
    task automatic send_edge(input logic signed [5:0] err, input int late);
        repeat (late) begin
            @(negedge i_ref_clk);
            o_phase_err = ~o_phase_err;
        end
        @(negedge i_ref_clk);
        o_resync_edge = 1'h1;
        o_phase_err   = err;
        @(negedge i_ref_clk);
        o_resync_edge = 1'h0;
        o_phase_err   = ~err;
    endtask

    task automatic start_seg();
        @(negedge i_ref_clk);
        o_seg_start = 1'h1;
        @(negedge i_ref_clk);
        o_seg_start = 1'h0;
    endtask
endmodule // cbtp_node_model

// ==== can_bit_timing_prop_sjw_test.sv ====
`timescale 1ns/1ps

module can_bit_timing_prop_sjw_test;
    import cbtp_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic              i_ref_clk;
    logic              i_rst;
    logic              i_sfr_wr;
    logic              i_sfr_rd;
    logic              i_controller_on_bit;
    logic [7:0]        i_sfr_addr;
    logic [7:0]        i_sfr_wdata;
    logic [7:0]        o_sfr_rdata;
    logic [5:0]        i_baud_prescaler;
    logic              seg_start;
    logic              resync_edge;
    logic signed [5:0] phase_err;
    logic              o_tq_tick;
    logic              o_prop_active;
    logic              o_prop_done;
    logic              o_resync_valid;
    logic signed [5:0] o_resync_adj;
    cbtp_sjw_t         o_resync_jump_width;
    cbtp_prs_t         o_propagation_segment;
    logic [7:0]        d;
    int                n_mismatch = 0;
    int                check_count = 0;
    int                n;
    int                e;
    int                lim;
    int                errs[3] = '{-5, 1, 5};

    cbtp_top uut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
        .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata),
        .i_controller_on_bit(i_controller_on_bit),
        .i_baud_prescaler(i_baud_prescaler),
        .i_seg_start(seg_start), .i_resync_edge(resync_edge),
        .i_phase_err(phase_err), .o_tq_tick(o_tq_tick),
        .o_prop_active(o_prop_active), .o_prop_done(o_prop_done),
        .o_resync_valid(o_resync_valid), .o_resync_adj(o_resync_adj),
        .o_resync_jump_width(o_resync_jump_width),
        .o_propagation_segment(o_propagation_segment)
    );

    cbtp_node_model node (
        .i_ref_clk(i_ref_clk), .o_seg_start(seg_start),
        .o_resync_edge(resync_edge), .o_phase_err(phase_err)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge i_ref_clk);
        i_sfr_addr  = a;
        i_sfr_wdata = v;
        i_sfr_wr    = 1'h1;
        @(negedge i_ref_clk);
        i_sfr_wr    = 1'h0;
    endtask

    // Called at a falling edge straight after a write, so the read
    // follows the write with no idle cycle between them.
    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
        i_sfr_addr = a;
        i_sfr_rd   = 1'h1;
        @(negedge i_ref_clk);
        i_sfr_rd   = 1'h0;
        v          = o_sfr_rdata;
    endtask

    // Timing is only reprogrammed with the controller off.
    task automatic prog(input logic [7:0] v);
        @(negedge i_ref_clk);
        i_controller_on_bit = 1'h0;
        sfr_wr(8'hb5, v);
        @(negedge i_ref_clk);
        i_controller_on_bit = 1'h1;
    endtask

    task automatic wait_tick(output int cnt);
        cnt = 0;
        do begin
            @(negedge i_ref_clk);
            cnt++;
        end while (o_tq_tick !== 1'h1 && cnt < 100);
    endtask

    // ------------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------------
    initial begin
        i_ref_clk = 1'h0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end

    initial begin
        #200000;
        n_mismatch++;
        test_done();
    end

    initial begin
        i_rst = 1'h1;
        i_sfr_wr = 1'h0;
        i_sfr_rd = 1'h0;
        i_sfr_addr = 8'h00;
        i_sfr_wdata = 8'h00;
        i_controller_on_bit = 1'h0;
        i_baud_prescaler = 6'h02;
        repeat (10) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_rst = 1'h0;
        check("rdata idle", o_sfr_rdata, 8'h00);
        check("active idle", 8'(o_prop_active), 8'h00);
        sfr_wr(8'hb5, 8'h6e);
        sfr_rd(8'hb5, d);
        check("readback", d, 8'h6e);
        check("jump field", o_resync_jump_width, 8'h03);
        check("prop field", o_propagation_segment, 8'h07);
        sfr_wr(8'hb5, 8'h24);
        sfr_rd(8'hb5, d);
        check("readback", d, 8'h24);
        sfr_wr(8'hb4, 8'h6e);
        sfr_rd(8'hb4, d);
        check("unmapped", d, 8'h00);
        check("jump kept", o_resync_jump_width, 8'h01);
        // Quantum period is prescaler plus one clocks.
        @(negedge i_ref_clk);
        i_controller_on_bit = 1'h1;
        wait_tick(n);
        check("first tick", 8'(n), 8'h03);
        wait_tick(n);
        check("tick period", 8'(n), 8'h03);
        // Segment lengths chosen to cover the round-trip bus delay.
        foreach (errs[i]) begin
            e = (i == 0) ? 0 : (i == 1) ? 2 : 7;
            prog(8'(e << 1));
            wait_tick(n);
            node.start_seg();
            n = 0;
            lim = 0;
            while (o_prop_done !== 1'h1 && lim < 100) begin
                if (o_tq_tick === 1'h1 && o_prop_active === 1'h1) begin
                    n++;
                end
                @(negedge i_ref_clk);
                lim++;
            end
            check("prop ticks", 8'(n), 8'(e + 1));
        end
        // Each correction is clamped to the jump width in quanta.
        for (int s = 0; s < 4; s++) begin
            prog(8'(s << 5));
            foreach (errs[i]) begin
                node.send_edge(6'(errs[i]), s);
                lim = s + 1;
                e = errs[i] > lim ? lim : (errs[i] < -lim ? -lim : errs[i]);
                check("valid", 8'(o_resync_valid), 8'h01);
                check("adjust", o_resync_adj, 8'(e));
            end
        end
        @(negedge i_ref_clk);
        i_controller_on_bit = 1'h0;
        node.send_edge(-6'sd3, 0);
        check("valid off", 8'(o_resync_valid), 8'h00);
        test_done();
    end
endmodule // can_bit_timing_prop_sjw_test
